//--- rtl/sfc_stats_top.sv
// Per-port frame statistics core: event capture, counter update engine, clear and read-out.
// Notes on behaviour
// - Count received high-class frames and received low-class frames per port.
// - Count transmitted high-class and low-class frames per port.
// - Count received broadcast frames and received multicast frames per port.
// - Count transmitted broadcast frames and transmitted multicast frames per port.
// - Bin each received frame by length into six bins, bump that bin.
// - Bin each transmitted frame into the same six bins.
// - Count received frames with CRC or alignment error.
// - Count received frames under 64 bytes with good CRC as undersize.
// - Count received frames over 1024 bytes with good CRC as oversize.
// - Count received frames under 64 bytes with bad CRC as fragments.
// - Count received frames over 1024 bytes with bad CRC as jabber.
// - Count received frames dropped because the receive buffer is full.
// - Keep a per-port total of errored received frames.
// - Count every collision seen while the port transmits.
// - Count frames abandoned for excess or late collision or aging.
// - Count frames refused because the transmit buffer is full.
// - Count transmitted frames and add their bytes to a transmit octet total.
// - A clear command returns every counter to zero.
// - A port index selects which port's full counter set is read out.
// - Count received frames and add their bytes to a receive octet total.
// - A counter passing twelve decimal digits wraps to zero and continues.
`timescale 1ns/100ps
`default_nettype none
module sfc_stats_top #(
	parameter int unsigned NPORTS = 24
) (
	input  wire logic                                  core_clk_in,
	input  wire logic                                  arst_n_in,
	input  wire sfc_pkg::sfc_rx_frame_type [NPORTS-1:0] rx_frame_in,
	input  wire sfc_pkg::sfc_tx_event_type [NPORTS-1:0] tx_event_in,
	input  wire logic                                  clear_in,
	input  wire logic                                  read_req_in,
	input  wire logic [7:0]                            read_port_in,
	output logic                                       busy_out,
	output logic                                       rd_valid_out,
	output logic [sfc_pkg::IDX_W-1:0]                  rd_index_out,
	output logic [sfc_pkg::CNT_W-1:0]                  rd_data_out
);
	localparam int unsigned PORT_W = (NPORTS > 1) ? $clog2(NPORTS) : 1;
	localparam int unsigned DEPTH = NPORTS * sfc_pkg::NCNT;
	localparam int unsigned ADDR_W = $clog2(DEPTH);
	localparam int unsigned IW = sfc_pkg::IDX_W;
	localparam int unsigned CW = sfc_pkg::CNT_W;

	typedef struct packed {
		sfc_pkg::sfc_state_type                 st;
		logic [NPORTS-1:0][sfc_pkg::NCNT-1:0]   pend;
		logic [NPORTS-1:0][sfc_pkg::LEN_W-1:0]  rx_len;
		logic [NPORTS-1:0][sfc_pkg::LEN_W-1:0]  tx_len;
		logic [PORT_W-1:0]                      rr;
		logic [ADDR_W-1:0]                      addr;
		logic [CW-1:0]                          add;
		logic [ADDR_W-1:0]                      walk;
		logic [PORT_W-1:0]                      dump_port;
		logic [IW-1:0]                          dump_k;
		logic                                   clr_req;
		logic                                   rd_req;
		logic                                   dv1;
		logic [IW-1:0]                          di1;
		logic                                   rd_valid;
		logic [IW-1:0]                          rd_index;
		logic [CW-1:0]                          rd_data;
		logic                                   busy;
	} sfc_core_state_type;

	sfc_core_state_type              s;
	sfc_core_state_type              next_s;
	logic [NPORTS-1:0][sfc_pkg::NCNT-1:0] cmask;
	logic                            found;
	logic [PORT_W-1:0]               sel_port;
	logic [IW-1:0]                   sel_cnt;
	logic [PORT_W:0]                 cand;
	logic                            ram_we;
	logic [ADDR_W-1:0]               ram_waddr;
	logic [CW-1:0]                   ram_wdata;
	logic                            ram_re;
	logic [ADDR_W-1:0]               ram_raddr;
	logic [CW-1:0]                   ram_rdata;
	logic [CW:0]                     wsum;

	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		sfc_frame_classify u_classify (
			.rx_in    (rx_frame_in[p]),
			.tx_in    (tx_event_in[p]),
			.mask_out (cmask[p])
		);
	end

	sfc_count_ram #(
		.DEPTH  (DEPTH),
		.WIDTH  (CW),
		.ADDR_W (ADDR_W)
	) u_ram (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.we_in       (ram_we),
		.waddr_in    (ram_waddr),
		.wdata_in    (ram_wdata),
		.re_in       (ram_re),
		.raddr_in    (ram_raddr),
		.rdata_out   (ram_rdata)
	);

	// Round-robin port choice so a busy low port cannot starve the high ports.
	always_comb begin
		found = 1'b0;
		sel_port = '0;
		sel_cnt = '0;
		cand = '0;
		for (int i = 0; i < NPORTS; i++) begin
			cand = (PORT_W+1)'(s.rr) + (PORT_W+1)'(i);
			if (cand >= (PORT_W+1)'(NPORTS)) begin
				cand = cand - (PORT_W+1)'(NPORTS);
			end
			if (!found && (|s.pend[cand[PORT_W-1:0]])) begin
				found = 1'b1;
				sel_port = cand[PORT_W-1:0];
			end
		end
		for (int c = sfc_pkg::NCNT - 1; c >= 0; c--) begin
			if (s.pend[sel_port][c]) begin
				sel_cnt = IW'(c);
			end
		end
	end

	always_comb begin
		next_s = s;
		ram_we = 1'b0;
		ram_waddr = '0;
		ram_wdata = '0;
		ram_re = 1'b0;
		ram_raddr = '0;
		wsum = '0;
		next_s.dv1 = 1'b0;
		next_s.rd_valid = s.dv1;
		next_s.rd_index = s.di1;
		if (s.dv1) begin
			next_s.rd_data = ram_rdata;
		end
		next_s.clr_req = s.clr_req | clear_in;
		// A read request while one is pending or running is ignored.
		if (read_req_in && !s.rd_req && s.st != sfc_pkg::ST_DUMP
			&& read_port_in < 8'(NPORTS)) begin
			next_s.rd_req = 1'b1;
			next_s.dump_port = PORT_W'(read_port_in);
		end
		case (s.st)
			sfc_pkg::ST_IDLE: begin
				if (s.clr_req) begin
					next_s.st = sfc_pkg::ST_CLEAR;
					next_s.walk = '0;
					next_s.clr_req = clear_in;
				end else if (s.rd_req) begin
					next_s.st = sfc_pkg::ST_DUMP;
					next_s.dump_k = '0;
					next_s.rd_req = 1'b0;
				end else if (found) begin
					ram_re = 1'b1;
					ram_raddr = ADDR_W'(int'(sel_port) * sfc_pkg::NCNT + int'(sel_cnt));
					next_s.addr = ram_raddr;
					if (int'(sel_cnt) == sfc_pkg::C_RX_OCT) begin
						next_s.add = CW'(s.rx_len[sel_port]);
					end else if (int'(sel_cnt) == sfc_pkg::C_TX_OCT) begin
						next_s.add = CW'(s.tx_len[sel_port]);
					end else begin
						next_s.add = CW'(1);
					end
					next_s.pend[sel_port][sel_cnt] = 1'b0;
					next_s.rr = (sel_port == PORT_W'(NPORTS - 1)) ? '0 : sel_port + 1'b1;
					next_s.st = sfc_pkg::ST_UPDATE;
				end
			end
			sfc_pkg::ST_UPDATE: begin
				wsum = {1'b0, ram_rdata} + {1'b0, s.add};
				ram_we = 1'b1;
				ram_waddr = s.addr;
				// Past twelve decimal digits the count restarts from zero.
				if (wsum > {1'b0, sfc_pkg::WRAP_LIMIT}) begin
					wsum = wsum - {1'b0, sfc_pkg::WRAP_LIMIT} - (CW+1)'(1);
				end
				ram_wdata = wsum[CW-1:0];
				next_s.st = sfc_pkg::ST_IDLE;
			end
			sfc_pkg::ST_DUMP: begin
				ram_re = 1'b1;
				ram_raddr = ADDR_W'(int'(s.dump_port) * sfc_pkg::NCNT + int'(s.dump_k));
				next_s.dv1 = 1'b1;
				next_s.di1 = s.dump_k;
				if (s.dump_k == IW'(sfc_pkg::NCNT - 1)) begin
					next_s.st = sfc_pkg::ST_IDLE;
				end else begin
					next_s.dump_k = s.dump_k + 1'b1;
				end
			end
			sfc_pkg::ST_CLEAR: begin
				ram_we = 1'b1;
				ram_waddr = s.walk;
				ram_wdata = '0;
				if (s.walk == ADDR_W'(DEPTH - 1)) begin
					next_s.st = sfc_pkg::ST_IDLE;
				end else begin
					next_s.walk = s.walk + 1'b1;
				end
			end
			default: begin
				next_s.st = sfc_pkg::ST_IDLE;
			end
		endcase
		// New events are merged after the service clear, so an arrival wins.
		for (int p = 0; p < NPORTS; p++) begin
			next_s.pend[p] = next_s.pend[p] | cmask[p];
			if (rx_frame_in[p].valid) begin
				next_s.rx_len[p] = rx_frame_in[p].len;
			end
			if (tx_event_in[p].eof) begin
				next_s.tx_len[p] = tx_event_in[p].len;
			end
		end
		next_s.busy = (next_s.st != sfc_pkg::ST_IDLE) || next_s.clr_req;
	end

	// The counter array holds garbage at power-up, so reset starts a clear walk.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s <= '0;
			s.clr_req <= sfc_pkg::CLR_AT_RESET;
			s.busy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign busy_out = s.busy;
	assign rd_valid_out = s.rd_valid;
	assign rd_index_out = s.rd_index;
	assign rd_data_out = s.rd_data;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	sequence s_rx0_good;
		rx_frame_in[0].valid && !rx_frame_in[0].buf_drop;
	endsequence

	sequence s_dump_enter;
		s.st == sfc_pkg::ST_IDLE && !s.clr_req && s.rd_req;
	endsequence

	// An older unserviced frame may still hold the other class bit, so only the own one is required.
	property p_rx_class;
		s_rx0_good |=> s.pend[0][sfc_pkg::C_RX_PKT]
			&& (s.pend[0][sfc_pkg::C_RX_HI] || !$past(rx_frame_in[0].class_high))
			&& (s.pend[0][sfc_pkg::C_RX_LO] || $past(rx_frame_in[0].class_high));
	endproperty
	a_rx_class: assert property (p_rx_class) else $error("rx class not captured");

	property p_tx_class;
		tx_event_in[0].eof && !tx_event_in[0].class_high |=> s.pend[0][sfc_pkg::C_TX_LO];
	endproperty
	a_tx_class: assert property (p_tx_class) else $error("tx low class lost");

	property p_rx_bin64;
		s_rx0_good and (rx_frame_in[0].len == sfc_pkg::LEN_MIN)
			|=> s.pend[0][sfc_pkg::C_RX_BIN0];
	endproperty
	a_rx_bin64: assert property (p_rx_bin64) else $error("64 byte bin missed");

	property p_under;
		s_rx0_good and (rx_frame_in[0].len < sfc_pkg::LEN_MIN) and rx_frame_in[0].crc_ok
			|=> s.pend[0][sfc_pkg::C_RX_UNDER];
	endproperty
	a_under: assert property (p_under) else $error("undersize not counted");

	property p_rx_drop;
		rx_frame_in[0].valid && rx_frame_in[0].buf_drop |=> s.pend[0][sfc_pkg::C_RX_DROP];
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("rx drop lost");

	property p_coll;
		tx_event_in[0].collision |=> s.pend[0][sfc_pkg::C_TX_COLL];
	endproperty
	a_coll: assert property (p_coll) else $error("collision lost");

	property p_clear_zero;
		s.st == sfc_pkg::ST_CLEAR |-> ram_we && ram_wdata == '0 && ram_waddr == s.walk;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear wrote nonzero");

	property p_dump_first;
		s_dump_enter |-> ##3 rd_valid_out && rd_index_out == '0;
	endproperty
	a_dump_first: assert property (p_dump_first) else $error("dump word 0 late");

	property p_wrap;
		s.st == sfc_pkg::ST_UPDATE && ({1'b0, ram_rdata} + {1'b0, s.add})
			> {1'b0, sfc_pkg::WRAP_LIMIT}
			|-> ram_wdata < s.add;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_update_next;
		s.st == sfc_pkg::ST_IDLE && !s.clr_req && !s.rd_req && found
			|=> s.st == sfc_pkg::ST_UPDATE ##1 s.st == sfc_pkg::ST_IDLE;
	endproperty
	a_update_next: assert property (p_update_next) else $error("update not 2 cycles");

	property p_rx_bcast;
		(s_rx0_good and rx_frame_in[0].bcast) |=> s.pend[0][sfc_pkg::C_RX_BC];
	endproperty
	a_rx_bcast: assert property (p_rx_bcast) else $error("rx broadcast lost");

	property p_tx_bin64;
		tx_event_in[0].eof && tx_event_in[0].len == sfc_pkg::LEN_MIN
			|=> s.pend[0][sfc_pkg::C_TX_BIN0];
	endproperty
	a_tx_bin64: assert property (p_tx_bin64) else $error("tx 64 byte bin missed");

	property p_frag;
		(s_rx0_good and (rx_frame_in[0].len < sfc_pkg::LEN_MIN) and !rx_frame_in[0].crc_ok)
			|=> s.pend[0][sfc_pkg::C_RX_FRAG];
	endproperty
	a_frag: assert property (p_frag) else $error("fragment not counted");

	property p_rx_err;
		(s_rx0_good and (rx_frame_in[0].len > sfc_pkg::LEN_MAX))
			|=> s.pend[0][sfc_pkg::C_RX_ERR];
	endproperty
	a_rx_err: assert property (p_rx_err) else $error("errored frame not totalled");

	property p_tx_drop;
		tx_event_in[0].abort |=> s.pend[0][sfc_pkg::C_TX_DROP];
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("tx drop lost");

	property p_tx_oct;
		tx_event_in[0].eof |=> s.pend[0][sfc_pkg::C_TX_OCT]
			&& s.tx_len[0] == $past(tx_event_in[0].len);
	endproperty
	a_tx_oct: assert property (p_tx_oct) else $error("tx octet length lost");

	property p_rx_top_bin;
		(s_rx0_good and (rx_frame_in[0].len >= sfc_pkg::LEN_MAX))
			|=> s.pend[0][sfc_pkg::C_RX_BIN0 + 5];
	endproperty
	a_rx_top_bin: assert property (p_rx_top_bin) else $error("long frame not in top bin");

	property p_wrap_range;
		s.st == sfc_pkg::ST_UPDATE |-> ram_wdata <= sfc_pkg::WRAP_LIMIT;
	endproperty
	a_wrap_range: assert property (p_wrap_range) else $error("counter above twelve digits");
endmodule : sfc_stats_top
`default_nettype wire

//--- pkg/sfc_pkg.sv
// Shared constants and types of the port frame statistics unit.
`default_nettype none
package sfc_pkg;
	localparam int unsigned CNT_W = 40;
	localparam logic [39:0] WRAP_LIMIT = 40'he8_d4a5_0fff;
	localparam int unsigned LEN_W = 16;
	localparam int unsigned IDX_W = 6;
	localparam int unsigned NCNT = 34;
	localparam logic [15:0] LEN_MIN = 16'h0040;
	localparam logic [15:0] LEN_B1 = 16'h0080;
	localparam logic [15:0] LEN_B2 = 16'h0100;
	localparam logic [15:0] LEN_B3 = 16'h0200;
	localparam logic [15:0] LEN_MAX = 16'h0400;
	localparam int unsigned C_RX_PKT = 0;
	localparam int unsigned C_RX_OCT = 1;
	localparam int unsigned C_RX_HI = 2;
	localparam int unsigned C_RX_LO = 3;
	localparam int unsigned C_RX_BC = 4;
	localparam int unsigned C_RX_MC = 5;
	localparam int unsigned C_TX_PKT = 6;
	localparam int unsigned C_TX_OCT = 7;
	localparam int unsigned C_TX_HI = 8;
	localparam int unsigned C_TX_LO = 9;
	localparam int unsigned C_TX_BC = 10;
	localparam int unsigned C_TX_MC = 11;
	localparam int unsigned C_RX_BIN0 = 12;
	localparam int unsigned C_TX_BIN0 = 18;
	localparam int unsigned C_RX_CRC = 24;
	localparam int unsigned C_RX_UNDER = 25;
	localparam int unsigned C_RX_OVER = 26;
	localparam int unsigned C_RX_FRAG = 27;
	localparam int unsigned C_RX_JAB = 28;
	localparam int unsigned C_RX_DROP = 29;
	localparam int unsigned C_RX_ERR = 30;
	localparam int unsigned C_TX_COLL = 31;
	localparam int unsigned C_TX_DROP = 32;
	localparam int unsigned C_TX_FIFO = 33;
	localparam logic CLR_AT_RESET = 1'h1;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_UPDATE = 2'h1,
		ST_DUMP   = 2'h3,
		ST_CLEAR  = 2'h2
	} sfc_state_type;

	typedef struct packed {
		logic             valid;
		logic [LEN_W-1:0] len;
		logic             crc_ok;
		logic             align_err;
		logic             class_high;
		logic             bcast;
		logic             mcast;
		logic             buf_drop;
	} sfc_rx_frame_type;

	typedef struct packed {
		logic             eof;
		logic [LEN_W-1:0] len;
		logic             class_high;
		logic             bcast;
		logic             mcast;
		logic             collision;
		logic             abort;
		logic             fifo_drop;
	} sfc_tx_event_type;
endpackage : sfc_pkg
`default_nettype wire

//--- rtl/sfc_count_ram.sv
// Counter storage: one write port and one read port with registered read data.
`timescale 1ns/100ps
`default_nettype none
module sfc_count_ram #(
	parameter int unsigned DEPTH  = 816,
	parameter int unsigned WIDTH  = 40,
	parameter int unsigned ADDR_W = 10
) (
	input  wire logic              core_clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              we_in,
	input  wire logic [ADDR_W-1:0] waddr_in,
	input  wire logic [WIDTH-1:0]  wdata_in,
	input  wire logic              re_in,
	input  wire logic [ADDR_W-1:0] raddr_in,
	output var  logic [WIDTH-1:0]  rdata_out
);
	logic [WIDTH-1:0] mem [DEPTH];

	// The array has no reset; the core walks it to zero after every reset.
	always_ff @(posedge core_clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= '0;
		end else if (re_in) begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule : sfc_count_ram
`default_nettype wire

//--- rtl/sfc_frame_classify.sv
// Turns one port's end-of-frame and transmit events into a mask of counters to bump.
`timescale 1ns/100ps
`default_nettype none
module sfc_frame_classify (
	input  wire sfc_pkg::sfc_rx_frame_type rx_in,
	input  wire sfc_pkg::sfc_tx_event_type tx_in,
	output logic [sfc_pkg::NCNT-1:0]       mask_out
);
	logic short_f;
	logic long_f;

	function automatic int unsigned len_bin(input logic [sfc_pkg::LEN_W-1:0] len);
		if (len <= sfc_pkg::LEN_MIN) begin
			return 0;
		end else if (len < sfc_pkg::LEN_B1) begin
			return 1;
		end else if (len < sfc_pkg::LEN_B2) begin
			return 2;
		end else if (len < sfc_pkg::LEN_B3) begin
			return 3;
		end else if (len < sfc_pkg::LEN_MAX) begin
			return 4;
		end
		return 5;
	endfunction : len_bin

	always_comb begin
		mask_out = '0;
		short_f = rx_in.len < sfc_pkg::LEN_MIN;
		long_f = rx_in.len > sfc_pkg::LEN_MAX;
		// A frame thrown away for lack of buffer room only counts as a drop.
		if (rx_in.valid && rx_in.buf_drop) begin
			mask_out[sfc_pkg::C_RX_DROP] = 1'b1;
		end else if (rx_in.valid) begin
			mask_out[sfc_pkg::C_RX_PKT] = 1'b1;
			mask_out[sfc_pkg::C_RX_OCT] = 1'b1;
			mask_out[sfc_pkg::C_RX_HI] = rx_in.class_high;
			mask_out[sfc_pkg::C_RX_LO] = !rx_in.class_high;
			mask_out[sfc_pkg::C_RX_BC] = rx_in.bcast;
			mask_out[sfc_pkg::C_RX_MC] = rx_in.mcast;
			mask_out[sfc_pkg::C_RX_BIN0 + len_bin(rx_in.len)] = 1'b1;
			mask_out[sfc_pkg::C_RX_CRC] = !rx_in.crc_ok || rx_in.align_err;
			mask_out[sfc_pkg::C_RX_UNDER] = short_f && rx_in.crc_ok;
			mask_out[sfc_pkg::C_RX_OVER] = long_f && rx_in.crc_ok;
			mask_out[sfc_pkg::C_RX_FRAG] = short_f && !rx_in.crc_ok;
			mask_out[sfc_pkg::C_RX_JAB] = long_f && !rx_in.crc_ok;
			mask_out[sfc_pkg::C_RX_ERR] = !rx_in.crc_ok || rx_in.align_err || short_f
				|| long_f;
		end
		if (tx_in.eof) begin
			mask_out[sfc_pkg::C_TX_PKT] = 1'b1;
			mask_out[sfc_pkg::C_TX_OCT] = 1'b1;
			mask_out[sfc_pkg::C_TX_HI] = tx_in.class_high;
			mask_out[sfc_pkg::C_TX_LO] = !tx_in.class_high;
			mask_out[sfc_pkg::C_TX_BC] = tx_in.bcast;
			mask_out[sfc_pkg::C_TX_MC] = tx_in.mcast;
			mask_out[sfc_pkg::C_TX_BIN0 + len_bin(tx_in.len)] = 1'b1;
		end
		mask_out[sfc_pkg::C_TX_COLL] = tx_in.collision;
		mask_out[sfc_pkg::C_TX_DROP] = tx_in.abort;
		mask_out[sfc_pkg::C_TX_FIFO] = tx_in.fifo_drop;
	end
endmodule : sfc_frame_classify
`default_nettype wire

//--- verification/sfc_mac_model.sv
// Behavioural model of the port MAC receive and transmit datapaths.
`timescale 1ns/100ps
`default_nettype none
module sfc_mac_model #(
	parameter int unsigned NPORTS = 2
) (
	input  wire logic                                  core_clk_in,
	output var  sfc_pkg::sfc_rx_frame_type [NPORTS-1:0] rx_frame_out,
	output var  sfc_pkg::sfc_tx_event_type [NPORTS-1:0] tx_event_out
);
	sfc_pkg::sfc_rx_frame_type [NPORTS-1:0] rx_stage = '0;
	sfc_pkg::sfc_tx_event_type [NPORTS-1:0] tx_stage = '0;

	initial begin
		rx_frame_out = '0;
		tx_event_out = '0;
	end

	task automatic stage_rx(input int p, input logic [15:0] len,
			input logic ok, al, hi, bc, mc, dr);
		rx_stage[p] = {1'b1, len, ok, al, hi, bc, mc, dr};
	endtask : stage_rx

	task automatic stage_tx(input int p, input logic eof, input logic [15:0] len,
			input logic hi, bc, mc, col, ab, fd);
		tx_stage[p] = {eof, len, hi, bc, mc, col, ab, fd};
	endtask : stage_tx

	// Every staged port fires in the same cycle, so simultaneous events are exercised.
	task automatic fire();
		sfc_pkg::sfc_rx_frame_type [NPORTS-1:0] rx_rel;
		sfc_pkg::sfc_tx_event_type [NPORTS-1:0] tx_rel;
		@(posedge core_clk_in);
		rx_frame_out <= rx_stage;
		tx_event_out <= tx_stage;
		rx_rel = ~rx_stage;
		tx_rel = ~tx_stage;
		for (int p = 0; p < NPORTS; p++) begin
			// Data fields are scrambled after the pulse and qualifiers cleared, so stale fields are never reused.
			rx_rel[p].valid = 1'b0;
			tx_rel[p].eof = 1'b0;
			tx_rel[p].collision = 1'b0;
			tx_rel[p].abort = 1'b0;
			tx_rel[p].fifo_drop = 1'b0;
		end
		@(posedge core_clk_in);
		rx_frame_out <= rx_rel;
		tx_event_out <= tx_rel;
		rx_stage = '0;
		tx_stage = '0;
	endtask : fire
endmodule : sfc_mac_model
`default_nettype wire

//--- verification/sfc_stats_top_tb.sv
// Self-checking testbench of the port frame statistics core.
`timescale 1ns/100ps
`default_nettype none
module sfc_stats_top_tb;
	localparam int unsigned NP = 2;
	logic                               core_clk_in;
	logic                               arst_n_in;
	logic                               clear_in;
	logic                               read_req_in;
	logic [7:0]                         read_port_in;
	logic                               busy_out;
	logic                               rd_valid_out;
	logic [sfc_pkg::IDX_W-1:0]          rd_index_out;
	logic [sfc_pkg::CNT_W-1:0]          rd_data_out;
	wire sfc_pkg::sfc_rx_frame_type [NP-1:0] rx_frame;
	wire sfc_pkg::sfc_tx_event_type [NP-1:0] tx_event;
	logic [39:0]                        exp_cnt [NP][sfc_pkg::NCNT];
	int                                 err_count = 0;
	int                                 cmp_count = 0;

	sfc_mac_model #(.NPORTS(NP)) u_sfc_mac_model (
		.core_clk_in (core_clk_in),
		.rx_frame_out(rx_frame),
		.tx_event_out(tx_event)
	);

	sfc_stats_top #(.NPORTS(NP)) u_sfc_stats_top (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.rx_frame_in (rx_frame),
		.tx_event_in (tx_event),
		.clear_in    (clear_in),
		.read_req_in (read_req_in),
		.read_port_in(read_port_in),
		.busy_out    (busy_out),
		.rd_valid_out(rd_valid_out),
		.rd_index_out(rd_index_out),
		.rd_data_out (rd_data_out)
	);

	initial core_clk_in = 1'b0;
	always #50 core_clk_in = ~core_clk_in;

	task automatic final_report();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [39:0] e, input logic [39:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic wait_idle(input int bound);
		int i;
		i = 0;
		while (busy_out !== 1'b0 && i < bound) begin
			@(posedge core_clk_in);
			#1;
			i++;
		end
		if (busy_out !== 1'b0) begin
			chk("busy_timeout", 40'h0, 40'h1);
			final_report();
		end
	endtask : wait_idle

	function automatic int bin(input logic [15:0] len);
		if (len <= 16'h0040) return 0;
		if (len <= 16'h007f) return 1;
		if (len <= 16'h00ff) return 2;
		if (len <= 16'h01ff) return 3;
		if (len <= 16'h03ff) return 4;
		return 5;
	endfunction : bin

	task automatic rx(input int p, input logic [15:0] len, input logic ok, al, hi, bc, mc, dr);
		u_sfc_mac_model.stage_rx(p, len, ok, al, hi, bc, mc, dr);
		if (dr) begin
			exp_cnt[p][sfc_pkg::C_RX_DROP]++;
			return;
		end
		exp_cnt[p][sfc_pkg::C_RX_PKT]++;
		exp_cnt[p][sfc_pkg::C_RX_OCT] += 40'(len);
		exp_cnt[p][hi ? sfc_pkg::C_RX_HI : sfc_pkg::C_RX_LO]++;
		if (bc) exp_cnt[p][sfc_pkg::C_RX_BC]++;
		if (mc) exp_cnt[p][sfc_pkg::C_RX_MC]++;
		exp_cnt[p][sfc_pkg::C_RX_BIN0 + bin(len)]++;
		if (!ok || al) exp_cnt[p][sfc_pkg::C_RX_CRC]++;
		if (len < 16'h0040) exp_cnt[p][ok ? sfc_pkg::C_RX_UNDER : sfc_pkg::C_RX_FRAG]++;
		if (len > 16'h0400) exp_cnt[p][ok ? sfc_pkg::C_RX_OVER : sfc_pkg::C_RX_JAB]++;
		if (!ok || al || len < 16'h0040 || len > 16'h0400) exp_cnt[p][sfc_pkg::C_RX_ERR]++;
	endtask : rx

	task automatic tx(input int p, input logic eof, input logic [15:0] len,
			input logic hi, bc, mc, col, ab, fd);
		u_sfc_mac_model.stage_tx(p, eof, len, hi, bc, mc, col, ab, fd);
		if (eof) begin
			exp_cnt[p][sfc_pkg::C_TX_PKT]++;
			exp_cnt[p][sfc_pkg::C_TX_OCT] += 40'(len);
			exp_cnt[p][hi ? sfc_pkg::C_TX_HI : sfc_pkg::C_TX_LO]++;
			if (bc) exp_cnt[p][sfc_pkg::C_TX_BC]++;
			if (mc) exp_cnt[p][sfc_pkg::C_TX_MC]++;
			exp_cnt[p][sfc_pkg::C_TX_BIN0 + bin(len)]++;
		end
		if (col) exp_cnt[p][sfc_pkg::C_TX_COLL]++;
		if (ab) exp_cnt[p][sfc_pkg::C_TX_DROP]++;
		if (fd) exp_cnt[p][sfc_pkg::C_TX_FIFO]++;
	endtask : tx

	// The gap keeps every pending update applied before the next frame on a port.
	task automatic step();
		u_sfc_mac_model.fire();
		repeat (210) @(posedge core_clk_in);
	endtask : step

	task automatic dump(input int p, input int words);
		int n;
		n = 0;
		@(posedge core_clk_in);
		read_req_in <= 1'b1;
		read_port_in <= 8'(p);
		@(posedge core_clk_in);
		read_req_in <= 1'b0;
		for (int i = 0; i < 60 && n < sfc_pkg::NCNT; i++) begin
			#1;
			if (rd_valid_out === 1'b1) begin
				chk($sformatf("rd_index p%0d", p), 40'(n), 40'(rd_index_out));
				chk($sformatf("counter p%0d i%0d", p, n), exp_cnt[p][n], rd_data_out);
				n++;
			end
			@(posedge core_clk_in);
		end
		chk("word_count", 40'(words), 40'(n));
		wait_idle(100);
	endtask : dump

	task automatic s_rx_kinds();
		rx(0, 16'h0040, 1, 0, 1, 1, 0, 0);
		rx(1, 16'h0400, 1, 0, 0, 0, 1, 0);
		step();
		rx(0, 16'h003f, 1, 0, 0, 0, 0, 0);
		rx(1, 16'h0041, 1, 0, 1, 0, 0, 0);
		step();
		rx(0, 16'h003f, 0, 0, 1, 0, 0, 0);
		rx(1, 16'h0401, 0, 0, 0, 0, 0, 0);
		step();
		rx(0, 16'h0401, 1, 0, 0, 1, 0, 0);
		rx(1, 16'h0200, 1, 1, 1, 0, 0, 0);
		step();
		rx(0, 16'h012c, 1, 0, 1, 1, 1, 1);
		rx(1, 16'h0080, 1, 0, 0, 1, 1, 0);
		step();
		rx(0, 16'h03ff, 1, 0, 1, 0, 1, 0);
		rx(1, 16'h0100, 0, 0, 0, 0, 0, 0);
		step();
		dump(0, 34);
		dump(1, 34);
	endtask : s_rx_kinds

	task automatic s_tx_kinds();
		tx(0, 1, 16'h007f, 1, 1, 0, 0, 0, 0);
		tx(1, 1, 16'h00ff, 0, 0, 1, 0, 0, 0);
		step();
		tx(0, 1, 16'h01ff, 0, 0, 0, 1, 0, 0);
		tx(1, 1, 16'h0400, 1, 0, 0, 0, 1, 1);
		step();
		tx(0, 1, 16'h0040, 0, 1, 1, 0, 0, 0);
		tx(1, 1, 16'h03ff, 1, 1, 0, 1, 0, 0);
		step();
		tx(0, 0, 16'h0000, 0, 0, 0, 1, 1, 1);
		tx(1, 1, 16'h0080, 0, 0, 1, 0, 0, 0);
		step();
		dump(0, 34);
		dump(1, 34);
	endtask : s_tx_kinds

	task automatic s_bad_port();
		dump(NP, 0);
	endtask : s_bad_port

	task automatic s_clear();
		@(posedge core_clk_in);
		clear_in <= 1'b1;
		@(posedge core_clk_in);
		clear_in <= 1'b0;
		#1;
		chk("busy_after_clear", 40'h1, 40'(busy_out));
		wait_idle(200);
		exp_cnt = '{default: '{default: 40'h0}};
		dump(0, 34);
		dump(1, 34);
	endtask : s_clear

	initial begin
		arst_n_in = 1'b0;
		clear_in = 1'b0;
		read_req_in = 1'b0;
		read_port_in = 8'h00;
		exp_cnt = '{default: '{default: 40'h0}};
		repeat (2) @(posedge core_clk_in);
		#1;
		chk("busy_in_reset", 40'h1, 40'(busy_out));
		chk("valid_in_reset", 40'h0, 40'(rd_valid_out));
		@(posedge core_clk_in);
		arst_n_in <= 1'b1;
		#1;
		wait_idle(300);
		dump(0, 34);
		s_rx_kinds();
		s_tx_kinds();
		s_bad_port();
		s_clear();
		final_report();
	end
endmodule : sfc_stats_top_tb
`default_nettype wire
